// ===== rpc_cmd_handler.sv
`timescale 1ns/100ps
// Contract
// - operation takes only 0x80 on, 0x00 off
// - off then on restart clears alarms
// - clear-faults clears status, releases ctl alert
// - clears from non-control port are ignored
// - persisting faults set again after clear
// - write guard 00 all, 80 none, 40 op
// - guard defaults 00, always writable, reads free
// - code 0x12 loads fixed factory defaults
// - code 0x16 loads user default set
// - 0x17 stores one, 0x18 restores one
// - format reads linear, exponent minus nine
// - setpoint mantissa 16 bits, scale 2^-9
// - words go low byte first, then PEC
// - pin sets voltage until software writes
// - input thresholds follow low/high line
// - fan setup is duty mode only
// - fan duty percent, 00 internal, over 100 error
// - ov reaction reads fixed latch-after-retries
// - ov retry 1 s, latch at 3/minute
// - restart paths leave latch, clear status
// - warn limits crossed assert alert
// - out-of-range value kept, data error flagged
`include "rpc_cfg.svh"
module rpc_cmd_handler #(
  parameter int unsigned SEC_CYCLES = `RPC_SYS_HZ
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire rpc_pkg::rpc_cmd_s cmd_i,
  input wire logic ctl_port_i,
  input wire logic onoff_pin_i,
  input wire logic high_line_i,
  input wire logic [15:0] vprog_i,
  input wire logic [15:0] vout_meas_i,
  output logic rsp_valid_o,
  output rpc_pkg::rpc_rsp_s rsp_o,
  output logic out_en_o,
  output logic [15:0] vout_target_o,
  output logic [7:0] fan_duty_o,
  output logic fan_ovr_o,
  output logic [1:0] alert_o,
  output logic latched_o
);
  import rpc_pkg::*;

  // ==========================================
  // state
  logic [17:0] pin_s1_q; // first sync stage
  logic [17:0] pin_s2_q; // pins usable here
  logic pin_prev_q; // on/off pin, last cycle
  logic op_on_q; // operation state
  logic [7:0] wp_q; // write guard
  logic [7:0] fcfg_q; // fan setup
  logic [15:0] par_q [0:5]; // live parameters
  logic sw_set_q; // software owns setpoint
  rpc_seq_e seq_q; // store sequencer
  rpc_idx_t idx_q; // sequencer index
  logic ld_v_q; // store data arrives now
  rpc_idx_t ld_idx_q; // where it goes
  logic [3:0] st_vout_q; // ov, ovw, uvw, uvf
  logic [7:0] cml_q; // comm status
  logic [1:0] alert_q; // per port alert
  logic [26:0] sec_cnt_q; // one second divider
  logic ov_off_q; // shut down, waiting retry
  logic latch_q; // latched off
  logic [1:0] tries_q; // shutdowns in window
  logic [5:0] retry_q; // seconds since trip
  logic [5:0] win_q; // seconds in window
  logic win_act_q; // window running
  logic out_en_q;
  logic [15:0] vtgt_q;
  logic [7:0] fan_q;
  logic fan_ovr_q;
  logic rsp_valid_q;
  rpc_rsp_s rsp_q;

  // ==========================================
  // decode helpers
  logic busy, pin_on, tick, ev, restart_ev;
  logic e_cmd, e_dat, e_oth, wp_blk;
  logic w_op, w_wp, w_par, w_fcfg;
  logic do_clr, do_fact, do_uall, do_sto, do_urst;
  logic [15:0] rdata;
  logic [3:0] cmap, dmap; // {valid, index}
  logic [3:0] vset; // status set terms
  logic [15:0] mem_rdata;
  logic ov_evt; // overvoltage trip this cycle
  logic [31:0] lim; // {low, high} of the addressed parameter
  logic mem_we;
  rpc_idx_t mem_addr;
  logic [15:0] mem_wdata;

  // code to parameter index
  function automatic logic [3:0] par_of(input logic [7:0] c);
    unique case (c)
      `RPC_C_VSET: par_of = {1'b1, `RPC_I_VSET};
      `RPC_C_FDUTY: par_of = {1'b1, `RPC_I_FAN};
      `RPC_C_OVF: par_of = {1'b1, `RPC_I_OVF};
      `RPC_C_OVW: par_of = {1'b1, `RPC_I_OVW};
      `RPC_C_UVW: par_of = {1'b1, `RPC_I_UVW};
      `RPC_C_UVF: par_of = {1'b1, `RPC_I_UVF};
      default: par_of = 4'h0;
    endcase
  endfunction : par_of

  // fixed factory value, not writable
  function automatic logic [15:0] fdef(input rpc_idx_t i);
    unique case (i)
      `RPC_I_VSET: fdef = `RPC_V54;
      `RPC_I_FAN: fdef = 16'h0000;
      `RPC_I_OVF: fdef = `RPC_V60;
      `RPC_I_OVW: fdef = `RPC_V59;
      `RPC_I_UVW: fdef = `RPC_V42;
      default: fdef = `RPC_V41;
    endcase
  endfunction : fdef

  // legal range per parameter, {low, high}
  function automatic logic [31:0] rng(input rpc_idx_t i);
    unique case (i)
      `RPC_I_VSET: rng = {`RPC_V41, `RPC_V59};
      `RPC_I_FAN: rng = {16'h0000, `RPC_FAN_MAX};
      `RPC_I_OVF: rng = {`RPC_V41, `RPC_V60};
      `RPC_I_OVW: rng = {`RPC_V42, `RPC_V59};
      `RPC_I_UVW: rng = {`RPC_V38, `RPC_V58};
      default: rng = {`RPC_V36, `RPC_V58};
    endcase
  endfunction : rng

  assign cmap = par_of(cmd_i.code);
  assign dmap = par_of(cmd_i.data[7:0]);
  assign lim = rng(cmap[2:0]);
  assign busy = (seq_q != SEQ_IDLE) || ld_v_q;
  assign pin_on = pin_s2_q[17];

  // ==========================================
  // pin synchronisers, two stages each
  // vprog is quasi static, so a bitwise sync is safe
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1_q <= 18'h00000;
      pin_s2_q <= 18'h00000;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {onoff_pin_i, high_line_i, vprog_i};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q[17];
    end
  end

  // guard 80 blocks every write but the exempt ones, 40 also lets op through, 00 blocks none
  always_comb begin
    wp_blk = 1'b0;
    if (cmd_i.wr && cmd_i.code != `RPC_C_WP && cmd_i.code != `RPC_C_CLR) begin
      if (wp_q == `RPC_WP_NONE) begin
        wp_blk = 1'b1;
      end else if (wp_q == `RPC_WP_OPONLY) begin
        wp_blk = (cmd_i.code != `RPC_C_OP);
      end
    end
  end

  // ==========================================
  // command decode
  always_comb begin
    e_cmd = 1'b0;
    e_dat = 1'b0;
    e_oth = 1'b0;
    rdata = 16'h0000;
    w_op = 1'b0;
    w_wp = 1'b0;
    w_par = 1'b0;
    w_fcfg = 1'b0;
    do_clr = 1'b0;
    do_fact = 1'b0;
    do_uall = 1'b0;
    do_sto = 1'b0;
    do_urst = 1'b0;
    if (!cmd_valid_i) begin
      e_oth = 1'b0; // nothing to do
    end else if (busy) begin
      e_oth = 1'b1; // store walk in progress
    end else if (!cmd_i.wr) begin
      // reads are never guarded
      if (cmap[3]) begin
        rdata = par_q[cmap[2:0]];
      end else begin
        unique case (cmd_i.code)
          `RPC_C_OP: rdata = {8'h00, op_on_q ? `RPC_OP_ON : `RPC_OP_OFF};
          `RPC_C_WP: rdata = {8'h00, wp_q};
          `RPC_C_VFMT: rdata = {8'h00, `RPC_VFMT};
          `RPC_C_VINON: rdata = pin_s2_q[16] ? `RPC_VINON_HL : `RPC_VINON_LL;
          `RPC_C_VINOFF: rdata = pin_s2_q[16] ? `RPC_VINOFF_HL : `RPC_VINOFF_LL;
          `RPC_C_FCFG: rdata = {8'h00, fcfg_q};
          `RPC_C_OVRSP: rdata = {8'h00, `RPC_OVRSP};
          `RPC_C_STV: rdata = {8'h00, st_vout_q, 4'h0};
          `RPC_C_CML: rdata = {8'h00, cml_q};
          default: e_cmd = 1'b1;
        endcase
      end
    end else if (wp_blk) begin
      e_cmd = 1'b1;
    end else if (cmap[3]) begin
      // range checked, old value kept on error
      if (cmd_i.data < lim[31:16] || cmd_i.data > lim[15:0]) begin
        e_dat = 1'b1;
      end else begin
        w_par = 1'b1;
      end
    end else begin
      unique case (cmd_i.code)
        `RPC_C_OP: begin
          if (cmd_i.data[7:0] == `RPC_OP_ON || cmd_i.data[7:0] == `RPC_OP_OFF) begin
            w_op = 1'b1;
          end else begin
            e_dat = 1'b1;
          end
        end
        `RPC_C_CLR: do_clr = (cmd_i.port == ctl_port_i);
        `RPC_C_WP: begin
          unique case (cmd_i.data[7:0])
            `RPC_WP_ALL, `RPC_WP_NONE, `RPC_WP_OPONLY: w_wp = 1'b1;
            default: e_dat = 1'b1;
          endcase
        end
        `RPC_C_FACT: do_fact = 1'b1;
        `RPC_C_UALL: do_uall = 1'b1;
        // guard register is not in the set, so it is refused here
        `RPC_C_USTO: begin
          do_sto = dmap[3];
          e_dat = !dmap[3];
        end
        `RPC_C_URST: begin
          do_urst = dmap[3];
          e_dat = !dmap[3];
        end
        `RPC_C_FCFG: begin
          w_fcfg = (cmd_i.data[7:0] == `RPC_FCFG_DUTY);
          e_dat = (cmd_i.data[7:0] != `RPC_FCFG_DUTY);
        end
        default: e_cmd = 1'b1; // read-only or unknown
      endcase
    end
  end

  // off to on by command or by the pin
  assign restart_ev = (w_op && !op_on_q && cmd_i.data[7:0] == `RPC_OP_ON)
                    || (pin_on && !pin_prev_q);

  // ==========================================
  // answer, one cycle after the command
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rsp_valid_q <= cmd_valid_i;
      rsp_q.nack <= e_cmd | e_dat | e_oth;
      rsp_q.data <= rdata; // port logic sends [7:0] first
    end
  end

  // operation, guard and fan setup
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      op_on_q <= 1'b1; // on at power up
      wp_q <= `RPC_WP_ALL;
      fcfg_q <= `RPC_FCFG_DUTY;
    end else begin
      if (w_op) begin
        op_on_q <= (cmd_i.data[7:0] == `RPC_OP_ON);
      end
      if (w_wp) begin
        wp_q <= cmd_i.data[7:0];
      end
      if (w_fcfg) begin
        fcfg_q <= cmd_i.data[7:0];
      end
    end
  end

  // ==========================================
  // live parameter set
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || do_fact) begin
      for (int i = 0; i < 6; i++) begin
        par_q[i] <= fdef(3'(i));
      end
    end else if (w_par) begin
      par_q[cmap[2:0]] <= cmd_i.data;
    end else if (ld_v_q) begin
      par_q[ld_idx_q] <= mem_rdata;
    end
  end

  // once software writes the setpoint the pin is ignored
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_set_q <= 1'b0;
    end else if (w_par && cmap[2:0] == `RPC_I_VSET) begin
      sw_set_q <= 1'b1;
    end
  end

  // ==========================================
  // user default store: fill, store, restore
  assign mem_we = (seq_q == SEQ_INIT) || do_sto;
  assign mem_addr = (seq_q == SEQ_IDLE) ? dmap[2:0] : idx_q;
  assign mem_wdata = (seq_q == SEQ_INIT) ? fdef(idx_q) : par_q[dmap[2:0]];

  rpc_user_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // walks the set once after reset and on restore-all
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seq_q <= SEQ_INIT;
      idx_q <= 3'h0;
      ld_v_q <= 1'b0;
      ld_idx_q <= 3'h0;
    end else begin
      ld_v_q <= 1'b0;
      unique case (seq_q)
        SEQ_INIT: begin
          idx_q <= idx_q + 3'h1;
          if (idx_q == `RPC_I_LAST) begin
            seq_q <= SEQ_IDLE;
          end
        end
        SEQ_IDLE: begin
          idx_q <= 3'h0;
          ld_idx_q <= dmap[2:0];
          ld_v_q <= do_urst;
          if (do_uall) begin
            seq_q <= SEQ_RDALL;
          end
        end
        SEQ_RDALL: begin
          ld_v_q <= 1'b1;
          ld_idx_q <= idx_q;
          idx_q <= idx_q + 3'h1;
          if (idx_q == `RPC_I_LAST) begin
            seq_q <= SEQ_IDLE;
          end
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================
  // status flags; a set in the clearing cycle wins
  assign vset = {(ov_evt | (latch_q & !restart_ev)),
                 out_en_q && vout_meas_i > par_q[`RPC_I_OVW],
                 out_en_q && vout_meas_i < par_q[`RPC_I_UVW],
                 out_en_q && vout_meas_i < par_q[`RPC_I_UVF]};
  assign ev = (|vset) | e_cmd | e_dat | e_oth;

  // trip only while driving and not yet tripped: out_en_q drops two cycles
  // after the trip, so without the gate a single trip would count twice
  assign ov_evt = out_en_q && !ov_off_q && !latch_q
                && vout_meas_i > par_q[`RPC_I_OVF];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_vout_q <= 4'h0;
      cml_q <= 8'h00;
      alert_q <= 2'h0;
    end else begin
      // live faults re-set right after a clear
      st_vout_q <= vset | (st_vout_q & {4{!(do_clr | restart_ev)}});
      cml_q <= {e_cmd, e_dat, 4'h0, e_oth, 1'b0}
             | (cml_q & {8{!(do_clr | restart_ev)}});
      // only the port in control is released by a clear
      alert_q <= {2{ev}} | (alert_q & ~({2{restart_ev}}
               | ({2{do_clr}} & (ctl_port_i ? 2'h2 : 2'h1))));
    end
  end

  // ==========================================
  // overvoltage retry and latch-off
  assign tick = (sec_cnt_q == 27'(SEC_CYCLES - 1));

  // restarted on a trip so the retry delay is a full second
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || ov_evt || tick) begin
      sec_cnt_q <= 27'h0000000;
    end else begin
      sec_cnt_q <= sec_cnt_q + 27'h0000001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || restart_ev) begin
      ov_off_q <= 1'b0;
      latch_q <= 1'b0;
      tries_q <= 2'h0;
      retry_q <= 6'h00;
      win_q <= 6'h00;
      win_act_q <= 1'b0;
    end else if (ov_evt) begin
      ov_off_q <= 1'b1;
      retry_q <= 6'h00;
      tries_q <= tries_q + 2'h1;
      latch_q <= (tries_q + 2'h1 == `RPC_OV_TRIES);
      if (!win_act_q) begin
        win_act_q <= 1'b1;
        win_q <= 6'h00;
      end
    end else if (tick && !latch_q) begin
      if (ov_off_q) begin
        if (retry_q + 6'h01 == `RPC_T_RETRY_S) begin
          ov_off_q <= 1'b0;
        end
        retry_q <= retry_q + 6'h01;
      end
      // a minute after the first trip: count and window start over
      if (win_act_q) begin
        if (win_q + 6'h01 == `RPC_T_WINDOW_S) begin
          win_act_q <= 1'b0;
          tries_q <= 2'h0;
        end
        win_q <= win_q + 6'h01;
      end
    end
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_en_q <= 1'b0;
      vtgt_q <= `RPC_V54;
      fan_q <= 8'h00;
      fan_ovr_q <= 1'b0;
    end else begin
      out_en_q <= op_on_q && pin_on && !ov_off_q && !latch_q;
      vtgt_q <= sw_set_q ? par_q[`RPC_I_VSET] : pin_s2_q[15:0];
      fan_q <= par_q[`RPC_I_FAN][7:0];
      fan_ovr_q <= (par_q[`RPC_I_FAN] != 16'h0000);
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o = rsp_q;
  assign out_en_o = out_en_q;
  assign vout_target_o = vtgt_q;
  assign fan_duty_o = fan_q;
  assign fan_ovr_o = fan_ovr_q;
  assign alert_o = alert_q;
  assign latched_o = latch_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_op_reject: assert property (cmd_valid_i && !busy && !wp_blk && cmd_i.wr
    && cmd_i.code == `RPC_C_OP && cmd_i.data[7:0] != 8'h80 && cmd_i.data[7:0] != 8'h00
    |=> rsp_q.nack && op_on_q == $past(op_on_q)) else $error("bad operation byte taken");
  a_wp_guard: assert property (cmd_valid_i && !busy && cmd_i.wr
    && wp_q == `RPC_WP_NONE && cmd_i.code != `RPC_C_WP && cmd_i.code != `RPC_C_CLR
    |=> rsp_q.nack) else $error("guarded write accepted");
  a_fmt_read: assert property (cmd_valid_i && !busy && !cmd_i.wr
    && cmd_i.code == `RPC_C_VFMT |=> !rsp_q.nack && rsp_q.data == 16'h0017)
    else $error("format read wrong");
  a_range_keep: assert property (cmd_valid_i && !busy && cmd_i.wr && !wp_blk
    && cmd_i.code == `RPC_C_VSET && cmd_i.data > `RPC_V59
    |=> rsp_q.nack && par_q[0] == $past(par_q[0])) else $error("range not kept");
  a_clr_alert: assert property (do_clr && !ev && !restart_ev
    |=> !alert_q[$past(ctl_port_i)]) else $error("alert not released");
  a_clr_foreign: assert property (cmd_valid_i && !busy && cmd_i.wr && !restart_ev
    && cmd_i.code == `RPC_C_CLR && cmd_i.port != ctl_port_i
    |=> (st_vout_q & $past(st_vout_q)) == $past(st_vout_q)) else $error("foreign clear");
  a_latch_off: assert property (latch_q |=> !out_en_q ##1 !out_en_q || !latch_q)
    else $error("latched unit drives");
  a_retry_tick: assert property ($fell(ov_off_q) && !$past(restart_ev) |-> $past(tick))
    else $error("retry off tick");
  a_warn_alert: assert property (ev |=> alert_q == 2'h3) else $error("alert missed");
  a_vprog: assert property (!sw_set_q |=> vtgt_q == $past(pin_s2_q[15:0]))
    else $error("pin not followed");
  a_restart: assert property (restart_ev |=> !latch_q && tries_q == 2'h0)
    else $error("restart kept latch");

  c_restart: cover property (restart_ev);
  c_latch: cover property ($rose(latch_q));
  c_rdall: cover property (seq_q == SEQ_RDALL ##6 seq_q == SEQ_IDLE);
  c_fan: cover property ($rose(fan_ovr_q));
endmodule : rpc_cmd_handler

// ===== rpc_cfg.svh
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
// ==========================================
// command codes
`define RPC_C_OP 8'h01
`define RPC_C_CLR 8'h03
`define RPC_C_WP 8'h10
`define RPC_C_FACT 8'h12
`define RPC_C_UALL 8'h16
`define RPC_C_USTO 8'h17
`define RPC_C_URST 8'h18
`define RPC_C_VFMT 8'h20
`define RPC_C_VSET 8'h21
`define RPC_C_VINON 8'h35
`define RPC_C_VINOFF 8'h36
`define RPC_C_FCFG 8'h3A
`define RPC_C_FDUTY 8'h3B
`define RPC_C_OVF 8'h40
`define RPC_C_OVRSP 8'h41
`define RPC_C_OVW 8'h42
`define RPC_C_UVW 8'h43
`define RPC_C_UVF 8'h44
`define RPC_C_STV 8'h7A
`define RPC_C_CML 8'h7E
// ==========================================
// data encodings and fixed read values
`define RPC_OP_ON 8'h80
`define RPC_OP_OFF 8'h00
`define RPC_WP_ALL 8'h00
`define RPC_WP_NONE 8'h80
`define RPC_WP_OPONLY 8'h40
`define RPC_VFMT 8'h17
`define RPC_OVRSP 8'h98
`define RPC_FCFG_DUTY 8'h88
`define RPC_VINON_LL 16'h0055
`define RPC_VINON_HL 16'h00B4
`define RPC_VINOFF_LL 16'h0050
`define RPC_VINOFF_HL 16'h00AA
// ==========================================
// parameter set: index, factory value, range
`define RPC_I_VSET 3'h0
`define RPC_I_FAN 3'h1
`define RPC_I_OVF 3'h2
`define RPC_I_OVW 3'h3
`define RPC_I_UVW 3'h4
`define RPC_I_UVF 3'h5
`define RPC_I_LAST 3'h5
`define RPC_V36 16'h4800
`define RPC_V38 16'h4C00
`define RPC_V41 16'h5200
`define RPC_V42 16'h5400
`define RPC_V54 16'h6C00
`define RPC_V58 16'h7400
`define RPC_V59 16'h7600
`define RPC_V60 16'h7800
`define RPC_FAN_MAX 16'h0064
// ==========================================
// timing (seconds) and shutdown count
`define RPC_SYS_HZ 125000000
`define RPC_T_RETRY_S 6'h01
`define RPC_T_WINDOW_S 6'h3C
`define RPC_OV_TRIES 2'h3
`endif

// ===== rpc_pkg.sv
// ==========================================
// shared types of the command handler
package rpc_pkg;
  // index into the stored parameter set
  typedef logic [2:0] rpc_idx_t;
  // one decoded bus command from the port logic
  typedef struct packed {
    logic port;
    logic wr;
    logic [7:0] code;
    logic [15:0] data;
  } rpc_cmd_s;
  // answer to a command, low byte in [7:0]
  typedef struct packed {
    logic nack;
    logic [15:0] data;
  } rpc_rsp_s;
  // default-store sequencer
  typedef enum logic [1:0] {
    SEQ_INIT = 2'b00,
    SEQ_IDLE = 2'b01,
    SEQ_RDALL = 2'b10
  } rpc_seq_e;
endpackage : rpc_pkg

// ===== rpc_user_mem.sv
`timescale 1ns/100ps
// ==========================================
// user default store, registered read
module rpc_user_mem (
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire rpc_pkg::rpc_idx_t addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);
  import rpc_pkg::*;
  // no reset: the sequencer fills it after reset
  logic [15:0] mem_q [0:7];

  // write and read share one address
  always_ff @(posedge clk_sys_i) begin
    if (wr_en_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end
endmodule : rpc_user_mem

// ===== rpc_host_model.sv
`timescale 1ns/100ps
// ==========================================
// host side of the command port
module rpc_host_model (
  input wire logic clk_sys_i,
  input wire logic rsp_valid_i,
  input wire rpc_pkg::rpc_rsp_s rsp_i,
  output logic cmd_valid_o,
  output rpc_pkg::rpc_cmd_s cmd_o
);
  import rpc_pkg::*;
  // idle port at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // one command: strobe for one edge; the answer stands for the one cycle
  // after that edge, so it is taken at the next falling edge
  task automatic xfer(input logic p, input logic w, input logic [7:0] c,
      input logic [15:0] d, output rpc_rsp_s r, output logic v);
    @(negedge clk_sys_i);
    cmd_o = {p, w, c, d};
    cmd_valid_o = 1'b1;
    @(negedge clk_sys_i);
    v = rsp_valid_i;
    r = rsp_i;
    cmd_valid_o = 1'b0;
    // released data is scrambled so stale values cannot pass
    cmd_o.data = ~d;
  endtask : xfer
endmodule : rpc_host_model

// ===== tb_top.sv
`timescale 1ns/100ps
`include "rpc_cfg.svh"
// ==========================================
// command handler bench
module tb_top;
  import rpc_pkg::*;
  localparam int SEC = 20; // cycles per second, shortened
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i, rsp_valid_o, out_en_o, fan_ovr_o, latched_o, v;
  logic ctl_port_i = 1'b0;
  logic onoff_pin_i = 1'b1;
  logic high_line_i = 1'b0;
  logic [15:0] vprog_i = 16'h6A00;
  logic [15:0] vout_meas_i = 16'h6C00;
  logic [15:0] vout_target_o;
  logic [7:0] fan_duty_o;
  logic [1:0] alert_o;
  logic [15:0] gd [3] = '{16'h0000, 16'h0080, 16'h0040};
  rpc_cmd_s cmd_i;
  rpc_rsp_s rsp_o, r;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  rpc_host_model i_rpc_host_model (.clk_sys_i(clk_sys_i), .rsp_valid_i(rsp_valid_o),
    .rsp_i(rsp_o), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
  rpc_cmd_handler #(.SEC_CYCLES(SEC)) i_rpc_cmd_handler (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .ctl_port_i(ctl_port_i),
    .onoff_pin_i(onoff_pin_i), .high_line_i(high_line_i), .vprog_i(vprog_i),
    .vout_meas_i(vout_meas_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
    .out_en_o(out_en_o), .vout_target_o(vout_target_o), .fan_duty_o(fan_duty_o),
    .fan_ovr_o(fan_ovr_o), .alert_o(alert_o), .latched_o(latched_o));
  // ==========================================
  // helpers
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : tick
  // command from a chosen side; answer strobe and refusal checked
  task automatic cmdp(input logic p, input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic nk);
    i_rpc_host_model.xfer(p, w, c, d, r, v);
    chk({14'h0, v, r.nack}, {14'h0, 1'b1, nk});
  endtask : cmdp
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
      input logic nk);
    cmdp(1'b0, w, c, d, nk);
  endtask : cmd
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    cmd(1'b0, c, 16'h0000, 1'b0);
    chk(r.data, e);
  endtask : rd
  // hang guard: far above the roughly 750 cycles needed
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    tick(10);
    rst_i = 1'b0;
    tick(10);
    chk(16'(out_en_o), 16'h0001);
    chk(vout_target_o, 16'h6A00);
    rd(`RPC_C_WP, 16'h0000);
    rd(`RPC_C_VFMT, 16'h0017);
    rd(`RPC_C_OVRSP, 16'h0098);
    rd(`RPC_C_VINON, `RPC_VINON_LL);
    rd(`RPC_C_VINOFF, `RPC_VINOFF_LL);
    high_line_i = 1'b1;
    tick(4);
    rd(`RPC_C_VINON, `RPC_VINON_HL);
    rd(`RPC_C_VINOFF, `RPC_VINOFF_HL);
    cmd(1'b1, `RPC_C_VSET, 16'h64E6, 1'b0);
    vprog_i = 16'h7000;
    tick(4);
    chk(vout_target_o, 16'h64E6);
    cmd(1'b1, `RPC_C_VSET, `RPC_V60, 1'b1);
    rd(`RPC_C_VSET, 16'h64E6);
    cmd(1'b0, `RPC_C_CML, 16'h0000, 1'b0);
    chk(16'(r.data[6]), 16'h0001);
    cmd(1'b1, `RPC_C_OP, 16'h0055, 1'b1);
    chk(16'(out_en_o), 16'h0001);
    // guard settings against op and setpoint writes
    for (int i = 0; i < 3; i++) begin
      cmd(1'b1, `RPC_C_WP, gd[i], 1'b0);
      cmd(1'b1, `RPC_C_OP, 16'h0080, 1'(i == 1));
      cmd(1'b1, `RPC_C_VSET, 16'h64E6, 1'(i != 0));
      rd(`RPC_C_VSET, 16'h64E6);
    end
    cmd(1'b1, `RPC_C_WP, 16'h0000, 1'b0);
    chk(16'(alert_o), 16'h0003);
    cmdp(1'b1, 1'b1, `RPC_C_CLR, 16'h0000, 1'b0);
    tick(2);
    chk(16'(alert_o), 16'h0003);
    cmd(1'b1, `RPC_C_CLR, 16'h0000, 1'b0);
    tick(2);
    chk(16'(alert_o), 16'h0002);
    rd(`RPC_C_CML, 16'h0000);
    vout_meas_i = 16'h7700;
    tick(3);
    rd(`RPC_C_STV, 16'h0040);
    cmd(1'b1, `RPC_C_CLR, 16'h0000, 1'b0);
    tick(2);
    chk(16'(alert_o), 16'h0003);
    rd(`RPC_C_STV, 16'h0040);
    vout_meas_i = 16'h5300;
    cmd(1'b1, `RPC_C_CLR, 16'h0000, 1'b0);
    tick(2);
    rd(`RPC_C_STV, 16'h0020);
    vout_meas_i = 16'h6C00;
    cmd(1'b1, `RPC_C_FCFG, `RPC_FCFG_DUTY, 1'b0);
    cmd(1'b1, `RPC_C_FDUTY, 16'h0064, 1'b0);
    cmd(1'b1, `RPC_C_FDUTY, 16'h0065, 1'b1);
    chk(16'({fan_ovr_o, fan_duty_o}), 16'h0164);
    cmd(1'b1, `RPC_C_FDUTY, 16'h0000, 1'b0);
    tick(1);
    chk(16'(fan_ovr_o), 16'h0000);
    cmd(1'b1, `RPC_C_VSET, 16'h6000, 1'b0);
    cmd(1'b1, `RPC_C_USTO, 16'h0021, 1'b0);
    cmd(1'b1, `RPC_C_VSET, 16'h6400, 1'b0);
    cmd(1'b1, `RPC_C_URST, 16'h0021, 1'b0);
    tick(2);
    chk(vout_target_o, 16'h6000);
    cmd(1'b1, `RPC_C_VSET, 16'h6400, 1'b0);
    cmd(1'b1, `RPC_C_UALL, 16'h0000, 1'b0);
    tick(8);
    chk(vout_target_o, 16'h6000);
    cmd(1'b1, `RPC_C_FACT, 16'h0000, 1'b0);
    tick(8);
    chk(vout_target_o, `RPC_V54);
    // overvoltage: trips one second apart, latch on the third
    for (int k = 0; k < 2; k++) begin
      vout_meas_i = 16'h7900;
      tick(3);
      chk(16'({out_en_o, latched_o}), 16'h0000);
      tick(SEC);
      chk(16'(latched_o), 16'h0000);
      tick(SEC + 4);
      chk(16'(latched_o), 16'h0001);
      vout_meas_i = 16'h6C00;
      tick(2 * SEC);
      if (k == 0) begin
        cmd(1'b1, `RPC_C_OP, 16'h0000, 1'b0);
        tick(20 * SEC);
        cmd(1'b1, `RPC_C_OP, 16'h0080, 1'b0);
      end else begin
        onoff_pin_i = 1'b0;
        tick(5);
        onoff_pin_i = 1'b1;
      end
      tick(5);
      chk(16'({out_en_o, latched_o}), 16'h0002);
      rd(`RPC_C_STV, 16'h0000);
    end
    finish_test();
  end
endmodule : tb_top
